// ### rtl/sax_pkg.sv
// package for the segment address extension block
// assumes a register file port (8-bit address/data) from the cpu core
package sax_pkg;
  localparam logic [7:0] DATA_PAGE0_ADDR = 8'hf0;
  localparam logic [7:0] PORT_DATA0_ADDR = 8'he0;
  localparam logic [7:0] CODE_SEGMENT_ADDR = 8'hf4;
  localparam logic [7:0] EXT_MODE_TWO_ADDR = 8'hf6;
  localparam logic [7:0] INTERRUPT_SEGMENT_ADDR = 8'hf8;
  localparam logic [7:0] DMA_SEGMENT_ADDR = 8'hf9;
  localparam int PAGE_SWAP_BIT = 5;
  localparam int SAVE_CS_BIT = 6;
  localparam logic [5:0] CODE_SEGMENT_RESET = 6'h00;
  localparam logic [7:0] EXT_MODE_RESET = 8'h00;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
  localparam logic [15:0] DIVZERO_VECTOR_ADDR = 16'h0002;
  localparam logic [15:0] TOP_VECTOR_ADDR = 16'h0004;
  localparam logic [5:0] RESET_SEGMENT = 6'h00;
  // kinds of memory access offered by the core
  typedef enum logic [4:0] {
    ACC_FETCH = 5'b00001,
    ACC_DATA = 5'b00010,
    ACC_DMA = 5'b00100,
    ACC_VECTOR = 5'b01000,
    ACC_RESET = 5'b10000
  } sax_access_t;
  // vector sources
  typedef enum logic [3:0] {
    VEC_CHANNEL = 4'b0001,
    VEC_TOP = 4'b0010,
    VEC_DIVZERO = 4'b0100,
    VEC_POWERON = 4'b1000
  } sax_vector_t;
endpackage

// ### rtl/sax_segment_ext.sv
// segment address extension and interrupt vector addressing
// forms the upper bits of every 22-bit physical address: six from a segment, eight from a data page
// outputs: reg_rdata and phys_addr are registered, decodes are not
// assumes register file port from the core on sys_clk, and the core's
// sequencer to drive interrupt entry/return and far control transfers
// assumes pin inputs are asynchronous and sys_clk is the only clock
// interrupt and dma segment and data page registers power up unknown: software loads them
// priority, nesting, the dma engine and vector registers live elsewhere
`timescale 1ns/1ns
`default_nettype none
module sax_segment_ext #(
  parameter int EXT_CHANNELS = 8,
  parameter int VEC_LOW_BITS = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register file port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  output logic reg_is_port_data,
  // memory access request from core or dma
  input wire sax_pkg::sax_access_t acc_kind,
  input wire logic [15:0] acc_vaddr,
  input wire logic dma_segment_select,
  output logic [21:0] phys_addr,
  // vector selection
  input wire sax_pkg::sax_vector_t vec_kind,
  input wire logic [7:0] vector_base_reg,
  input wire logic [VEC_LOW_BITS-1:0] vec_channel_bits,
  input wire logic vec_high_byte,
  // core sequencer events
  input wire logic far_load,
  input wire logic [5:0] far_segment,
  input wire logic int_entry,
  input wire logic int_return,
  input wire logic trap_entry,
  input wire logic [5:0] popped_segment,
  output logic push_segment,
  output logic push_flags,
  output logic [5:0] pushed_segment,
  output logic in_service,
  output logic [7:0] data_page_regs_flat [4],
  // external interrupt pins and top level selection
  input wire logic [EXT_CHANNELS-1:0] ext_int_pin,
  input wire logic [EXT_CHANNELS-1:0] ext_rising_sel,
  input wire logic nmi_pin,
  input wire logic watchdog_event,
  input wire logic top_from_nmi,
  output logic [EXT_CHANNELS-1:0] ext_edge_seen,
  output logic top_event
);
  // segment and mode registers
  logic [5:0] int_seg_q;
  logic [5:0] dma_seg_q;
  logic [5:0] code_seg_q;
  logic [7:0] ext_mode_q;
  logic [7:0] page_q [4];

  // service state
  logic isr_active_q;
  logic saved_mode_q;

  // decoded controls and address parts
  logic save_en;
  logic swap_en;
  logic [5:0] fetch_seg;
  logic [7:0] vec_low;
  logic [7:0] dp_base;
  logic [7:0] pd_base;

  // top level pin synchroniser
  logic [2:0] nmi_sync_q;
  logic nmi_level_q;

  // mode bits decoded once so every process sees the same value
  assign save_en = ext_mode_q[sax_pkg::SAVE_CS_BIT];
  assign swap_en = ext_mode_q[sax_pkg::PAGE_SWAP_BIT];
  // data pages live at their home slots or are swapped with port data
  // swapping keeps both blocks reachable, just at exchanged slots
  assign dp_base = swap_en ? sax_pkg::PORT_DATA0_ADDR
                           : sax_pkg::DATA_PAGE0_ADDR;
  assign pd_base = swap_en ? sax_pkg::DATA_PAGE0_ADDR
                           : sax_pkg::PORT_DATA0_ADDR;
  // page contents exported for the data address path of the core
  assign data_page_regs_flat = page_q;

  // segment registers: only six bits are kept, contents undefined at reset
  // so no reset branch; the cpu must program them before use
  // only the interrupt and dma segments live here; each keeps six bits
  // a write and a use in one cycle see the old value
  always_ff @(posedge sys_clk) begin
    if (reg_wr && reg_addr == sax_pkg::INTERRUPT_SEGMENT_ADDR) begin
      int_seg_q <= reg_wdata[5:0];
    end
    if (reg_wr && reg_addr == sax_pkg::DMA_SEGMENT_ADDR) begin
      dma_seg_q <= reg_wdata[5:0];
    end
  end

  // data page registers, undefined at reset as well
  // one register per page; an address match writes all eight bits
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_page
      always_ff @(posedge sys_clk) begin
        if (reg_wr && reg_addr == dp_base + 8'(p)) begin
          page_q[p] <= reg_wdata;
        end
      end
    end
  endgenerate

  // extended mode register; only swap and save bits are meaningful here
  // other bits are stored and read back but drive nothing in this block
  // reset clears both bits: legacy entry and home page slots
  // a write takes effect at the next access, never mid-access
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_mode_q <= sax_pkg::EXT_MODE_RESET;
    end else if (reg_wr && reg_addr == sax_pkg::EXT_MODE_TWO_ADDR) begin
      ext_mode_q <= reg_wdata;
    end
  end

  // code segment: far transfers, interrupt entry/return, guarded writes
  // entry with saving loads the interrupt segment; the old value is pushed
  // return pops it only if saving was in force when the routine began
  // a far transfer beats a direct write in the same cycle
  // reset value zero lets the first fetch come from segment zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      code_seg_q <= sax_pkg::CODE_SEGMENT_RESET;
    end else if (int_entry && save_en) begin
      code_seg_q <= int_seg_q;
    end else if (int_return && saved_mode_q) begin
      code_seg_q <= popped_segment;
    end else if (far_load) begin
      code_seg_q <= far_segment;
    end else if (reg_wr && reg_addr == sax_pkg::CODE_SEGMENT_ADDR) begin
      // direct write is only safe while the register is idle
      // bits 7:6 are dropped as for the other segments
      code_seg_q <= reg_wdata[5:0];
    end
  end

  // service state: remembers the mode in force at entry for the return
  // latching the mode keeps a mode change inside a routine from upsetting
  // the matching return; an entry and a return in one cycle: entry wins
  // in_service is registered: it rises the cycle after the entry pulse
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      isr_active_q <= 1'b0;
      saved_mode_q <= 1'b0;
    end else if (int_entry) begin
      isr_active_q <= 1'b1;
      saved_mode_q <= save_en;
    end else if (int_return) begin
      isr_active_q <= 1'b0;
      saved_mode_q <= 1'b0;
    end
  end
  assign in_service = isr_active_q;

  // stack frame control; trap pushes pc only
  // a divide-by-zero trap pushes neither flags nor segment here; the core
  // pushes the program counter on its own
  // pushed_segment is the value before any load at this entry edge
  always_comb begin
    push_flags = int_entry;
    push_segment = int_entry && save_en;
  end
  assign pushed_segment = code_seg_q;

  // fetch segment: interrupt segment replaces code segment in legacy mode
  // with saving on, the code segment already holds the interrupt segment
  // legacy routines cannot leave the interrupt segment: a far transfer
  // writes the code segment, which is unused until the return
  assign fetch_seg = (isr_active_q && !saved_mode_q) ? int_seg_q
                                                     : code_seg_q;

  // low vector byte: programmed base above, hardware channel bits below
  // base bits below VEC_LOW_BITS are ignored and overlaid by hardware
  always_comb begin
    vec_low = {vector_base_reg[7:VEC_LOW_BITS], vec_channel_bits};
  end

  // physical address; data registered so the bus sees a clean value
  // the default arms hold the last address if a request code is illegal
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phys_addr <= {sax_pkg::RESET_SEGMENT, sax_pkg::RESET_VECTOR_ADDR};
    end else begin
      unique case (acc_kind)
        sax_pkg::ACC_FETCH: begin
          // covers code in unused table slots too
          // fetch uses the service segment only in legacy mode
          phys_addr <= {fetch_seg, acc_vaddr};
        end
        sax_pkg::ACC_DATA: begin
          // same paging in and out of service
          // the top two virtual bits pick the page register
          phys_addr <= {page_q[acc_vaddr[15:14]], acc_vaddr[13:0]};
        end
        sax_pkg::ACC_DMA: begin
          // select comes from the pointer of the channel in use; dma never
          // uses the code segment, so far transfers cannot move it
          if (dma_segment_select) begin
            phys_addr <= {dma_seg_q, acc_vaddr};
          end else begin
            phys_addr <= {int_seg_q, acc_vaddr};
          end
        end
        sax_pkg::ACC_VECTOR: begin
          // every vector is a byte pair; vec_high_byte picks the odd byte
          unique case (vec_kind)
            sax_pkg::VEC_CHANNEL: begin
              // the channel bits above bit 0 pick one pair within the programmed base; vec_high_byte replaces channel bit 0
              phys_addr <= {int_seg_q, 8'h00,
                            vec_low[7:1], vec_high_byte};
            end
            sax_pkg::VEC_TOP: begin
              // top level pair sits at a fixed place in the table
              phys_addr <= {int_seg_q, sax_pkg::TOP_VECTOR_ADDR[15:1],
                            vec_high_byte};
            end
            sax_pkg::VEC_DIVZERO: begin
              // each code segment carries its own trap vector pair
              phys_addr <= {code_seg_q, sax_pkg::DIVZERO_VECTOR_ADDR[15:1],
                            vec_high_byte};
            end
            sax_pkg::VEC_POWERON: begin
              // same pair as the reset access, via the vector path
              phys_addr <= {sax_pkg::RESET_SEGMENT,
                            sax_pkg::RESET_VECTOR_ADDR[15:1],
                            vec_high_byte};
            end
            default: begin
              phys_addr <= phys_addr;
            end
          endcase
        end
        sax_pkg::ACC_RESET: begin
          // reset fetch ignores all segment registers, which may be unknown
          phys_addr <= {sax_pkg::RESET_SEGMENT, sax_pkg::RESET_VECTOR_ADDR[15:1],
                        vec_high_byte};
        end
        default: begin
          phys_addr <= phys_addr;
        end
      endcase
    end
  end

  // register read path; reserved segment bits read zero
  // unused addresses read zero so the register file can merge answers
  // data page slots follow the swap bit; the port data slots are served
  // by the register file outside this block
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
      if (reg_addr == sax_pkg::INTERRUPT_SEGMENT_ADDR) begin
        reg_rdata <= {2'b00, int_seg_q};
      end else if (reg_addr == sax_pkg::DMA_SEGMENT_ADDR) begin
        reg_rdata <= {2'b00, dma_seg_q};
      end else if (reg_addr == sax_pkg::CODE_SEGMENT_ADDR) begin
        reg_rdata <= {2'b00, code_seg_q};
      end else if (reg_addr == sax_pkg::EXT_MODE_TWO_ADDR) begin
        reg_rdata <= ext_mode_q;
      end else if (reg_addr[7:2] == dp_base[7:2]) begin
        reg_rdata <= page_q[reg_addr[1:0]];
      end
    end
  end

  // decode flags for the rest of the register file
  // reg_hit tells the register file that this block answers the access
  // port data slots move with the swap bit so the file can redirect them
  // combinational: valid in the cycle the address stands
  always_comb begin
    reg_is_port_data = reg_addr[7:2] == pd_base[7:2];
    reg_hit = reg_addr == sax_pkg::INTERRUPT_SEGMENT_ADDR ||
              reg_addr == sax_pkg::DMA_SEGMENT_ADDR ||
              reg_addr == sax_pkg::CODE_SEGMENT_ADDR ||
              reg_addr == sax_pkg::EXT_MODE_TWO_ADDR ||
              reg_addr[7:2] == dp_base[7:2];
  end

  // external channels: three-stage sync, edge counts once stages agree
  // the chain shifts every cycle; only the last two stages are compared
  // a one-cycle glitch on a pin never reaches the edge output
  // ext_rising_sel high counts rising edges, low counts falling edges
  // pulses last one cycle; the interrupt logic must latch them
  genvar g;
  generate
    for (g = 0; g < EXT_CHANNELS; g++) begin : g_ext
      // last agreed level; resets low to match an idle low pin
      logic [2:0] sync_q;
      logic level_q;
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          sync_q <= 3'b000;
          level_q <= 1'b0;
          ext_edge_seen[g] <= 1'b0;
        end else begin
          sync_q <= {sync_q[1:0], ext_int_pin[g]};
          ext_edge_seen[g] <= 1'b0;
          if (sync_q[1] == sync_q[2] && sync_q[2] != level_q) begin
            level_q <= sync_q[2];
            ext_edge_seen[g] <= (sync_q[2] == ext_rising_sel[g]);
          end
        end
      end
    end
  endgenerate

  // top level channel from nmi pin or watchdog
  // the pin idles high, so the chain resets high and no false edge follows
  // the watchdog pulse is already on sys_clk and needs no synchroniser
  // with the pin selected, watchdog pulses are ignored
  // top_event is registered: one cycle after a watchdog pulse, on the fourth edge after an nmi pin fall
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nmi_sync_q <= 3'b111;
      nmi_level_q <= 1'b1;
      top_event <= 1'b0;
    end else begin
      nmi_sync_q <= {nmi_sync_q[1:0], nmi_pin};
      top_event <= top_from_nmi ? 1'b0 : watchdog_event;
      if (nmi_sync_q[1] == nmi_sync_q[2] && nmi_sync_q[2] != nmi_level_q) begin
        nmi_level_q <= nmi_sync_q[2];
        // a rising edge only updates the stored level
        if (top_from_nmi && !nmi_sync_q[2]) begin
          top_event <= 1'b1; // falling edge of nmi
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/sax_segment_ext_checker.sv
// assertions on the segment address extension ports
// assumes a bind onto sax_segment_ext and one clock domain
`timescale 1ns/1ns
`default_nettype none
module sax_segment_ext_checker (
  // clock, reset and register port
  input wire logic sys_clk, reset, reg_wr, reg_rd, reg_hit,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  // memory access and vectors
  input wire sax_pkg::sax_access_t acc_kind,
  input wire sax_pkg::sax_vector_t vec_kind,
  input wire logic [15:0] acc_vaddr,
  input wire logic dma_segment_select, vec_high_byte,
  input wire logic [21:0] phys_addr,
  // sequencer events
  input wire logic int_entry, trap_entry, push_segment, push_flags,
  input wire logic in_service, top_event
);
  logic [5:0] isg_q, dsg_q;
  logic save_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // shadow segments are not reset, just as in the block itself
  always_ff @(posedge sys_clk) begin
    if (reg_wr && reg_addr == 8'hf8) isg_q <= reg_wdata[5:0];
    if (reg_wr && reg_addr == 8'hf9) dsg_q <= reg_wdata[5:0];
  end
  // shadow of the save bit of the mode register
  always_ff @(posedge sys_clk) begin
    if (reset) save_q <= 1'b0;
    else if (reg_wr && reg_addr == 8'hf6) save_q <= reg_wdata[6];
  end
  property p_seg_read;
    reg_rd && reg_addr[7:1] == 7'h7c |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_seg_read: assert property (p_seg_read) else $error("bits 7:6 set");
  property p_unmapped;
    reg_rd && !reg_hit |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_dma_own;
    acc_kind == sax_pkg::ACC_DMA && dma_segment_select
      |=> phys_addr == {$past(dsg_q), $past(acc_vaddr)};
  endproperty
  a_dma_own: assert property (p_dma_own) else $error("dma segment");
  property p_dma_int;
    acc_kind == sax_pkg::ACC_DMA && !dma_segment_select
      |=> phys_addr == {$past(isg_q), $past(acc_vaddr)};
  endproperty
  a_dma_int: assert property (p_dma_int) else $error("dma int seg");
  property p_top_vec;
    acc_kind == sax_pkg::ACC_VECTOR && vec_kind == sax_pkg::VEC_TOP
      |=> phys_addr == {$past(isg_q), 15'h0002, $past(vec_high_byte)};
  endproperty
  a_top_vec: assert property (p_top_vec) else $error("top vector");
  property p_poweron;
    acc_kind == sax_pkg::ACC_RESET |=> phys_addr[21:1] == 21'h0;
  endproperty
  a_poweron: assert property (p_poweron) else $error("reset vec");
  property p_legacy;
    int_entry && !save_q |-> push_flags && !push_segment ##1 in_service;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy entry");
  property p_save;
    int_entry && save_q |-> push_flags && push_segment;
  endproperty
  a_save: assert property (p_save) else $error("save entry");
  property p_trap;
    trap_entry && !int_entry |-> !push_flags && !push_segment;
  endproperty
  a_trap: assert property (p_trap) else $error("trap pushed");
  c_save: cover property (int_entry && save_q);
  c_dma: cover property (acc_kind == sax_pkg::ACC_DMA && dma_segment_select);
  c_top: cover property (top_event);
endmodule
bind sax_segment_ext sax_segment_ext_checker chk (.sys_clk, .reset,
  .reg_wr, .reg_rd, .reg_hit, .reg_addr, .reg_wdata, .reg_rdata,
  .acc_kind, .vec_kind, .acc_vaddr, .dma_segment_select, .vec_high_byte,
  .phys_addr, .int_entry, .trap_entry, .push_segment, .push_flags,
  .in_service, .top_event);
`default_nettype wire

// ### testbench/sax_core_model.sv
// core side model: register file port and memory access requests
// assumes the bench calls its tasks; sys_clk runs free
`timescale 1ns/1ns
`default_nettype none
module sax_core_model (
  // clock
  input wire logic sys_clk,
  // register file port
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  input wire logic [7:0] reg_rdata,
  // memory access
  output sax_pkg::sax_access_t acc_kind = sax_pkg::ACC_FETCH,
  output logic [15:0] acc_vaddr = 16'h0000,
  output logic dma_segment_select = 1'b0,
  input wire logic [21:0] phys_addr
);
  // write held over one taking edge; data line inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    {reg_wr, reg_wdata} <= {1'b0, ~d};
  endtask
  // read data is registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // one access; the code segment is never written while it drives fetch
  task automatic acc(input sax_pkg::sax_access_t k, input logic [15:0] v,
                     input logic s, output logic [21:0] p);
    @(posedge sys_clk);
    acc_kind <= k;
    acc_vaddr <= v;
    dma_segment_select <= s;
    @(posedge sys_clk);
    #1 p = phys_addr;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_segment_address_extension.sv
// bench for sax_segment_ext: registers, address forming, vectors, events
// assumes sax_core_model drives the register and access ports
`timescale 1ns/1ns
`default_nettype none
module tb_segment_address_extension;
  logic sys_clk = 1'b0, reset = 1'b1, reg_wr, reg_rd, reg_hit, sel;
  logic reg_is_port_data, push_segment, push_flags, in_service, top_event;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, ext_edge_seen;
  logic [7:0] dpr [4];
  logic [15:0] acc_vaddr;
  logic [21:0] phys_addr, pa;
  logic [5:0] pushed_segment, seg = 6'h00;
  sax_pkg::sax_access_t acc_kind;
  sax_pkg::sax_vector_t vk = sax_pkg::VEC_TOP;
  logic hb = 1'b0, far = 1'b0, ent = 1'b0, ret = 1'b0, trp = 1'b0;
  logic nmi = 1'b1, wdog = 1'b0, nmi_sel = 1'b0;
  logic [7:0] pins = 8'h00;
  logic [8:0] ev;
  int miscompares = 0, comparisons = 0, cycles = 0;
  sax_core_model core (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .acc_kind, .acc_vaddr, .dma_segment_select(sel), .phys_addr);
  sax_segment_ext uut (.sys_clk, .reset, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_hit, .reg_is_port_data, .acc_kind,
    .acc_vaddr, .dma_segment_select(sel), .phys_addr, .vec_kind(vk),
    .vector_base_reg(8'ha4), .vec_channel_bits(2'b11), .vec_high_byte(hb),
    .far_load(far), .far_segment(seg), .int_entry(ent), .int_return(ret),
    .trap_entry(trp), .popped_segment(seg), .push_segment, .push_flags,
    .pushed_segment, .in_service, .data_page_regs_flat(dpr),
    .ext_int_pin(pins), .ext_rising_sel(8'h0f), .nmi_pin(nmi),
    .watchdog_event(wdog), .top_from_nmi(nmi_sel), .ext_edge_seen,
    .top_event);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic check(input string n, input logic [21:0] e, g);
    comparisons++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // w picks entry, trap, return, far load; e is {flags, segment, pushed}
  task automatic pulse(input int w, input logic [7:0] e, input logic [5:0] s);
    @(posedge sys_clk);
    {far, ret, trp, ent} <= 4'h1 << w;
    seg <= s;
    #1 check("push", e, {push_flags, push_segment, pushed_segment});
    @(posedge sys_clk);
    {far, ret, trp, ent} <= 4'h0;
  endtask
  task automatic vec(input sax_pkg::sax_vector_t t, input logic h,
                     input logic [21:0] e);
    @(posedge sys_clk);
    vk <= t;
    hb <= h;
    core.acc(t == sax_pkg::VEC_POWERON ? sax_pkg::ACC_RESET :
             sax_pkg::ACC_VECTOR, 16'h0000, 1'b0, pa);
    check("vector", e, pa);
  endtask
  // edge pulses may land on the edge that ends the stimulus
  task automatic wait_ev(output logic [8:0] v);
    #1 v = {top_event, ext_edge_seen};
    for (int i = 0; i < 9 && v == 9'h0; i++) begin
      @(posedge sys_clk);
      #1 v = {top_event, ext_edge_seen};
    end
  endtask
  // timeout guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    core.wr(8'hf8, 8'hea);
    core.wr(8'hf9, 8'h15);
    core.rd(8'hf8, rd);
    check("interrupt_segment", 22'h2a, {14'h0, rd});
    core.rd(8'hf9, rd);
    check("dma_segment", 22'h15, {14'h0, rd});
    core.rd(8'h10, rd);
    check("unmapped", 22'h0, {14'h0, rd});
    core.acc(sax_pkg::ACC_DMA, 16'h1234, 1'b1, pa);
    check("dma", {6'h15, 16'h1234}, pa);
    core.acc(sax_pkg::ACC_DMA, 16'hfedc, 1'b0, pa);
    check("dma", {6'h2a, 16'hfedc}, pa);
    core.acc(sax_pkg::ACC_FETCH, 16'h8001, 1'b0, pa);
    check("fetch", {6'h00, 16'h8001}, pa);
    pulse(3, 8'h00, 6'h05);
    core.acc(sax_pkg::ACC_FETCH, 16'h0100, 1'b0, pa);
    check("fetch", {6'h05, 16'h0100}, pa);
    core.wr(8'hf1, 8'h9a);
    #1 check("page1", 22'h9a, {14'h0, dpr[1]});
    core.acc(sax_pkg::ACC_DATA, 16'h4abc, 1'b0, pa);
    check("data", {8'h9a, 14'h0abc}, pa);
    $display("test address forming done");
    vec(sax_pkg::VEC_TOP, 1'b0, {6'h2a, 16'h0004});
    vec(sax_pkg::VEC_TOP, 1'b1, {6'h2a, 16'h0005});
    vec(sax_pkg::VEC_DIVZERO, 1'b1, {6'h05, 16'h0003});
    vec(sax_pkg::VEC_CHANNEL, 1'b0, {6'h2a, 16'h00a6});
    vec(sax_pkg::VEC_POWERON, 1'b1, 22'h1);
    $display("test vectors done");
    pulse(0, 8'h85, 6'h00);
    #1 check("in_service", 22'h1, {21'h0, in_service});
    core.acc(sax_pkg::ACC_FETCH, 16'h0040, 1'b0, pa);
    check("fetch", {6'h2a, 16'h0040}, pa);
    pulse(2, 8'h05, 6'h00);
    core.wr(8'hf6, 8'h40);
    pulse(0, 8'hc5, 6'h00);
    core.acc(sax_pkg::ACC_FETCH, 16'h0040, 1'b0, pa);
    check("fetch", {6'h2a, 16'h0040}, pa);
    core.acc(sax_pkg::ACC_DATA, 16'h4abc, 1'b0, pa);
    check("data", {8'h9a, 14'h0abc}, pa);
    pulse(2, 8'h2a, 6'h05);
    core.rd(8'hf4, rd);
    check("code_segment", 22'h05, {14'h0, rd});
    pulse(1, 8'h05, 6'h00);
    core.wr(8'hf6, 8'h60);
    core.rd(8'he1, rd);
    check("swapped page", 22'h9a, {14'h0, rd});
    core.rd(8'hf1, rd);
    check("port_data", 22'h100, {13'h0, reg_is_port_data, rd});
    $display("test interrupts done");
    @(posedge sys_clk);
    pins <= 8'hff;
    wait_ev(ev);
    check("edges", 22'h0f, {13'h0, ev});
    @(posedge sys_clk);
    pins <= 8'h00;
    wait_ev(ev);
    check("edges", 22'hf0, {13'h0, ev});
    @(posedge sys_clk);
    wdog <= 1'b1;
    @(posedge sys_clk);
    wdog <= 1'b0;
    wait_ev(ev);
    check("top", 22'h100, {13'h0, ev});
    @(posedge sys_clk);
    nmi_sel <= 1'b1;
    @(posedge sys_clk);
    nmi <= 1'b0;
    wait_ev(ev);
    check("top", 22'h100, {13'h0, ev});
    $display("test events done");
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    core.rd(8'hf6, rd);
    check("mode after reset", 22'h0, {14'h0, rd});
    core.acc(sax_pkg::ACC_FETCH, 16'h0000, 1'b0, pa);
    check("fetch after reset", 22'h0, pa);
    check("in_service", 22'h0, {21'h0, in_service});
    $display("test reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
